// >>> rtl/cam_monitor.sv
// Commutation angle monitor with model, filter and fault timer.
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module cam_monitor
    import cam_pkg::*;
#(
    parameter int POLE_PAIRS = 4
)
(
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic SAMPLE,
    input wire logic signed [15:0] VEL,
    input wire logic signed [15:0] IQ,
    input wire logic signed [15:0] ID,
    input wire logic signed [15:0] UQ,
    input wire logic signed [15:0] UD,
    input wire logic [2:0] LEGACY_FAULT,
    input wire logic ERR_CLEAR,
    output logic COMM_FAULT,
    output logic MODEL_ACTIVE,
    output logic [15:0] ESTIMATE
);
    // ************************************************************
    // Configuration and status registers.
    // ************************************************************
    logic [31:0] feat;
    logic [15:0] vlim;
    logic [15:0] alim;
    logic [15:0] tol;
    logic [15:0] lpf_hz;
    logic [15:0] res;
    logic [15:0] ind;
    logic [7:0] lslope;
    logic fault;
    logic [15:0] raw;

    // ************************************************************
    // Register decode.
    // ************************************************************
    wire wr_feat = WR && (ADDR == CAM_OFS_FEAT);
    wire wr_vlim = WR && (ADDR == CAM_OFS_VLIM);
    wire wr_alim = WR && (ADDR == CAM_OFS_ALIM);
    wire wr_tol = WR && (ADDR == CAM_OFS_TOL);
    wire wr_lpf = WR && (ADDR == CAM_OFS_LPF);
    wire wr_res = WR && (ADDR == CAM_OFS_RES);
    wire wr_ind = WR && (ADDR == CAM_OFS_IND);
    wire wr_lslope = WR && (ADDR == CAM_OFS_LSLOPE);
    wire wr_stat = WR && (ADDR == CAM_OFS_STAT);

    // Writes beyond the allowed ranges are clamped, not refused.
    wire [15:0] alim_in = (WDATA[15:0] > CAM_ALIM_MAX) ?
                          CAM_ALIM_MAX : WDATA[15:0];
    wire [15:0] lpf_in = (WDATA[15:0] > CAM_LPF_MAX) ? CAM_LPF_MAX :
                         (WDATA[15:0] < CAM_LPF_MIN) ? CAM_LPF_MIN :
                         WDATA[15:0];

    // The model only works with the feature bit set; older triggers set the fault without it.
    wire feat_en = feat[CAM_FEAT_BIT];

    // ************************************************************
    // Velocity gate.
    // ************************************************************
    wire signed [16:0] vel_wide = {VEL[15], VEL};
    wire [16:0] vel_abs = VEL[15] ? 17'(-vel_wide) : 17'(vel_wide);
    wire active = feat_en && (vel_abs > {1'b0, vlim});

    // ************************************************************
    // Electrical model of the winding.
    // ************************************************************
    // A current-dependent inductance drops linearly with |iq|, floored
    // at one eighth so a steep slope cannot make it vanish.
    wire signed [16:0] iq_wide = {IQ[15], IQ};
    wire [16:0] iq_abs = IQ[15] ? 17'(-iq_wide) : 17'(iq_wide);
    wire [63:0] l_drop = 64'(cam_mul_shift(longint'(ind),
                         longint'(iq_abs) * longint'(lslope),
                         CAM_SH_LSLOPE));
    wire [15:0] l_floor = ind >> CAM_SH_LFLOOR;
    wire [15:0] l_lin = (l_drop >= 64'(ind - l_floor)) ? l_floor :
                        16'(ind - l_drop[15:0]);
    // Besides the read path, the inductance register feeds nothing but this model.
    wire [15:0] l_eff = (lslope != 8'h00) ? l_lin : ind;

    wire signed [63:0] w_scale = longint'(VEL) * longint'(POLE_PAIRS) *
                                 CAM_K_W;
    wire signed [63:0] r_d = cam_mul_shift(longint'(res) *
                             longint'(ID), CAM_K_R, CAM_SH_R);
    wire signed [63:0] r_q = cam_mul_shift(longint'(res) *
                             longint'(IQ), CAM_K_R, CAM_SH_R);
    wire signed [63:0] x_d = cam_mul_shift(cam_mul_shift(longint'(l_eff),
                             longint'(IQ), CAM_SH_L), w_scale,
                             CAM_SH_W);
    wire signed [63:0] x_q = cam_mul_shift(cam_mul_shift(longint'(l_eff),
                             longint'(ID), CAM_SH_L), w_scale,
                             CAM_SH_W);

    // Residuals are the induced voltage split by the angle error.
    wire signed [63:0] e_d = longint'(UD) - (r_d - x_d);
    wire signed [63:0] e_q_raw = longint'(UQ) - (r_q + x_q);
    wire signed [63:0] e_q = VEL[15] ? -e_q_raw : e_q_raw;
    wire [31:0] e_d_abs = e_d[63] ? 32'(-e_d) : 32'(e_d);
    // A non-positive q residual means the field leads past 90 degrees.
    wire beyond_quarter = (e_q <= 64'sd0);
    wire [31:0] den_in = e_d_abs + 32'(e_q);

    // ************************************************************
    // Sequential divider: ratio of |e_d| to |e_d| + e_q in Q13.
    // ************************************************************
    // The ratio is monotone in the angle and reaches one at 90
    // degrees, which scales to pi/2 without a trig table.
    cam_div_state_t state;
    cam_div_state_t next_state;
    logic [45:0] rem;
    logic [45:0] den;
    logic [13:0] quo;
    logic [3:0] step;

    wire start = SAMPLE && active && !beyond_quarter && (state == CAM_IDLE);
    wire [45:0] den_sh = den << step;
    wire take = (rem >= den_sh);
    wire last = (step == 4'h0);
    wire [63:0] angle = 64'(cam_mul_shift(longint'(quo | 14'(take)),
                        longint'(CAM_ANGLE_HALF_PI), 13));

    always_comb begin
        next_state = state;
        unique case (state)
            CAM_IDLE: begin
                if (start) begin
                    next_state = CAM_DIVIDE;
                end
            end
            CAM_DIVIDE: begin
                if (last || !active) begin
                    next_state = CAM_IDLE;
                end
            end
        endcase
    end

    // Divider datapath, one quotient bit per cycle.
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            state <= CAM_IDLE;
            rem <= 46'h0;
            den <= 46'h0;
            quo <= 14'h0000;
            step <= 4'h0;
        end else begin
            state <= next_state;
            if (start) begin
                rem <= {e_d_abs, 14'h0000} >> 1;
                den <= {14'h0000, den_in};
                quo <= 14'h0000;
                step <= 4'(CAM_DIV_STEPS - 1);
            end else if (state == CAM_DIVIDE) begin
                if (take) begin
                    rem <= rem - den_sh;
                    quo <= quo | (14'h0001 << step);
                end
                step <= step - 4'h1;
            end
        end
    end

    // Raw deviation: the divider result, or pi past a quarter turn.
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            raw <= 16'h0000;
        end else if (!active) begin
            raw <= 16'h0000;
        end else if (SAMPLE && beyond_quarter) begin
            raw <= CAM_ANGLE_PI;
        end else if (state == CAM_DIVIDE && last && take) begin
            raw <= angle[15:0];
        end else if (state == CAM_DIVIDE && last) begin
            raw <= 16'(cam_mul_shift(longint'(quo), longint'(
                   CAM_ANGLE_HALF_PI), 13));
        end
    end

    // ************************************************************
    // Filter rate divider and the millisecond tick.
    // ************************************************************
    logic [9:0] div_cnt;
    logic [6:0] ms_cnt;
    wire filt_tick = (div_cnt == 10'(CAM_FILT_DIV - 1));
    wire ms_tick = filt_tick && (ms_cnt == 7'(CAM_MS_TICKS - 1));

    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            div_cnt <= 10'h000;
            ms_cnt <= 7'h00;
        end else begin
            div_cnt <= filt_tick ? 10'h000 : div_cnt + 10'h001;
            if (filt_tick) begin
                ms_cnt <= (ms_cnt == 7'(CAM_MS_TICKS - 1)) ? 7'h00 :
                          ms_cnt + 7'h01;
            end
        end
    end

    // ************************************************************
    // Low-pass filter of the raw deviation.
    // ************************************************************
    cam_lpf_if lpf_bus ();
    wire [63:0] alpha_w = 64'(cam_mul_shift(longint'(lpf_hz),
                          CAM_ALPHA_K, CAM_ALPHA_SH));
    assign lpf_bus.tick = filt_tick;
    assign lpf_bus.clear = !active;
    assign lpf_bus.alpha = alpha_w[15:0];
    assign lpf_bus.x = raw;

    cam_lpf u_lpf (
        .clk(CLOCK),
        .nrst(NRST),
        .lpf(lpf_bus.filter)
    );

    // ************************************************************
    // Limit comparison and tolerance timer.
    // ************************************************************
    logic [15:0] over_ms;
    wire above = active && (lpf_bus.y > alim);
    // Strictly longer than the tolerance; one millisecond grain.
    wire dev_fault = above && (over_ms > tol);
    wire legacy = |LEGACY_FAULT;
    wire clear_req = ERR_CLEAR || (wr_stat && WDATA[CAM_STAT_FAULT]);

    always_ff @(posedge CLOCK) begin
        if (!NRST || !above) begin
            over_ms <= 16'h0000;
        end else if (ms_tick && over_ms != 16'hFFFF) begin
            over_ms <= over_ms + 16'h0001;
        end
    end

    // A new trigger in the clearing cycle keeps the flag set.
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            fault <= 1'b0;
        end else if (dev_fault || legacy) begin
            fault <= 1'b1;
        end else if (clear_req) begin
            fault <= 1'b0;
        end
    end

    // ************************************************************
    // Configuration register writes.
    // ************************************************************
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            feat <= CAM_RST_FEAT;
            vlim <= CAM_RST_VLIM;
            alim <= CAM_RST_ALIM;
            tol <= CAM_RST_TOL;
            lpf_hz <= CAM_RST_LPF;
            res <= CAM_RST_RES;
            ind <= CAM_RST_IND;
            lslope <= CAM_RST_LSLOPE;
        end else begin
            if (wr_feat) feat <= WDATA;
            if (wr_vlim) vlim <= WDATA[15:0];
            if (wr_alim) alim <= alim_in;
            if (wr_tol) tol <= WDATA[15:0];
            if (wr_lpf) lpf_hz <= lpf_in;
            if (wr_res) res <= WDATA[15:0];
            if (wr_ind) ind <= WDATA[15:0];
            if (wr_lslope) lslope <= WDATA[7:0];
        end
    end

    // ************************************************************
    // Read path, answered in the next cycle only.
    // ************************************************************
    wire [31:0] stat_word = {29'h0, above, active, fault};
    wire [31:0] rd_mux =
        (ADDR == CAM_OFS_FEAT) ? feat :
        (ADDR == CAM_OFS_VLIM) ? {16'h0000, vlim} :
        (ADDR == CAM_OFS_ALIM) ? {16'h0000, alim} :
        (ADDR == CAM_OFS_TOL) ? {16'h0000, tol} :
        (ADDR == CAM_OFS_LPF) ? {16'h0000, lpf_hz} :
        (ADDR == CAM_OFS_RES) ? {16'h0000, res} :
        (ADDR == CAM_OFS_IND) ? {16'h0000, ind} :
        (ADDR == CAM_OFS_LSLOPE) ? {24'h000000, lslope} :
        (ADDR == CAM_OFS_STAT) ? stat_word :
        (ADDR == CAM_OFS_EST) ? {16'h0000, lpf_bus.y} :
        (ADDR == CAM_OFS_RAW) ? {16'h0000, raw} : 32'h0000_0000;

    always_ff @(posedge CLOCK) begin
        if (!NRST || !RD) begin
            RDATA <= 32'h0000_0000;
        end else begin
            RDATA <= rd_mux;
        end
    end

    // Outputs to the drive come from flip-flops.
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            ESTIMATE <= 16'h0000;
            MODEL_ACTIVE <= 1'b0;
        end else begin
            ESTIMATE <= lpf_bus.y;
            MODEL_ACTIVE <= active;
        end
    end
    assign COMM_FAULT = fault;
endmodule
`default_nettype wire

// >>> rtl/cam_pkg.sv
// Constants and types shared by the commutation angle monitor files.
package cam_pkg;

    // ************************************************************
    // Register offsets, byte addresses on the register port.
    // ************************************************************
    localparam logic [7:0] CAM_OFS_FEAT = 8'h00;
    localparam logic [7:0] CAM_OFS_VLIM = 8'h04;
    localparam logic [7:0] CAM_OFS_ALIM = 8'h08;
    localparam logic [7:0] CAM_OFS_TOL = 8'h0C;
    localparam logic [7:0] CAM_OFS_LPF = 8'h10;
    localparam logic [7:0] CAM_OFS_RES = 8'h14;
    localparam logic [7:0] CAM_OFS_IND = 8'h18;
    localparam logic [7:0] CAM_OFS_LSLOPE = 8'h1C;
    localparam logic [7:0] CAM_OFS_STAT = 8'h20;
    localparam logic [7:0] CAM_OFS_EST = 8'h24;
    localparam logic [7:0] CAM_OFS_RAW = 8'h28;

    // ************************************************************
    // Field positions.
    // ************************************************************
    localparam int CAM_FEAT_BIT = 21;
    localparam int CAM_STAT_FAULT = 0;
    localparam int CAM_STAT_ACTIVE = 1;
    localparam int CAM_STAT_ABOVE = 2;

    // ************************************************************
    // Reset values. Angles are unsigned Q3.13 radians.
    // ************************************************************
    localparam logic [31:0] CAM_RST_FEAT = 32'h0020_0000;
    localparam logic [15:0] CAM_RST_VLIM = 16'h012C;
    localparam logic [15:0] CAM_RST_ALIM = 16'h2000;
    localparam logic [15:0] CAM_ALIM_MAX = 16'h323D;
    localparam logic [15:0] CAM_ANGLE_PI = 16'h6488;
    localparam logic [15:0] CAM_ANGLE_HALF_PI = 16'h3244;
    localparam logic [15:0] CAM_RST_TOL = 16'h0003;
    localparam logic [15:0] CAM_RST_LPF = 16'h001E;
    localparam logic [15:0] CAM_LPF_MAX = 16'h03E8;
    localparam logic [15:0] CAM_LPF_MIN = 16'h0001;
    localparam logic [15:0] CAM_RST_RES = 16'h09A6;
    localparam logic [15:0] CAM_RST_IND = 16'h61A8;
    localparam logic [7:0] CAM_RST_LSLOPE = 8'h00;

    // ************************************************************
    // Timing: filter update rate and the millisecond tick.
    // ************************************************************
    localparam int CAM_CLK_HZ = 40_000_000;
    localparam int CAM_FILT_HZ = 64_000;
    localparam int CAM_FILT_DIV = CAM_CLK_HZ / CAM_FILT_HZ;
    localparam int CAM_MS_TICKS = CAM_FILT_HZ / 1000;

    // ************************************************************
    // Fixed-point scale factors of the model and the filter.
    // ************************************************************
    // Filter coefficient in Q16 is corner * 2 pi / 64 kHz.
    localparam longint CAM_ALPHA_K = 64'sh0000_0000_0000_19BC;
    localparam int CAM_ALPHA_SH = 10;
    // Milliohm times milliampere to millivolt, about 1/1000.
    localparam longint CAM_K_R = 64'sh0000_0000_0000_0419;
    localparam int CAM_SH_R = 20;
    // Microhenry times milliampere scaled by 1/1024 first.
    localparam int CAM_SH_L = 10;
    // Times rpm and pole pairs to electrical rad/s and millivolt.
    localparam longint CAM_K_W = 64'sh0000_0000_0001_C1C1;
    localparam int CAM_SH_W = 30;
    // Inductance reduction and its floor at one eighth.
    localparam int CAM_SH_LSLOPE = 24;
    localparam int CAM_SH_LFLOOR = 3;
    localparam int CAM_DIV_STEPS = 14;

    typedef enum logic {
        CAM_IDLE,
        CAM_DIVIDE
    } cam_div_state_t;

    // Signed product with arithmetic shift, kept wide.
    function automatic longint cam_mul_shift(input longint a,
                                             input longint b,
                                             input int sh);
        cam_mul_shift = (a * b) >>> sh;
    endfunction

endpackage

// >>> rtl/cam_lpf_if.sv
// Interface between the monitor and its low-pass filter.
`timescale 1ns/100ps
`default_nettype none
interface cam_lpf_if;
    logic tick;
    logic clear;
    logic [15:0] alpha;
    logic [15:0] x;
    logic [15:0] y;

    modport owner (output tick, output clear, output alpha, output x,
                   input y);
    modport filter (input tick, input clear, input alpha, input x,
                    output y);
endinterface
`default_nettype wire

// >>> rtl/cam_lpf.sv
// First-order low-pass filter for the commutation deviation.
`timescale 1ns/100ps
`default_nettype none
module cam_lpf
    import cam_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    cam_lpf_if.filter lpf
);
    logic [31:0] acc;
    logic signed [32:0] diff;
    logic signed [49:0] step;
    logic [31:0] next_acc;

    // ************************************************************
    // Update y += alpha * (x - y), with 16 fraction bits of state.
    // ************************************************************
    // Keeping the fraction avoids a dead band at small corners.
    assign diff = $signed({1'b0, lpf.x, 16'h0000}) - $signed({1'b0, acc});
    assign step = (diff * $signed({1'b0, lpf.alpha})) >>> 16;
    assign next_acc = acc + step[31:0];
    assign lpf.y = acc[31:16];

    // The state follows the tick only; clear wins over a tick.
    always_ff @(posedge clk) begin
        if (!nrst || lpf.clear) begin
            acc <= 32'h0000_0000;
        end else if (lpf.tick) begin
            acc <= next_acc;
        end
    end
endmodule
`default_nettype wire

// >>> verif/cam_monitor_chk.sv
// Port assertions for the commutation angle monitor.
`timescale 1ns/100ps
`default_nettype none
module cam_monitor_chk
    import cam_pkg::*;
#(
    parameter int POLE_PAIRS = 4
)
(
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [31:0] RDATA,
    input wire logic [2:0] LEGACY_FAULT,
    input wire logic ERR_CLEAR,
    input wire logic COMM_FAULT,
    input wire logic MODEL_ACTIVE,
    input wire logic [15:0] ESTIMATE
);
    // ************************************************************
    // Properties on the register port, the fault flag and the model outputs.
    // ************************************************************
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!NRST);

    // Over-range writes followed at once by a read of the same place.
    sequence s_alim_big;
        WR && ADDR == CAM_OFS_ALIM && WDATA[31:16] == 16'h0000
            && WDATA[15:0] > CAM_ALIM_MAX;
    endsequence
    sequence s_lpf_big;
        WR && ADDR == CAM_OFS_LPF && WDATA[31:16] == 16'h0000
            && WDATA[15:0] > CAM_LPF_MAX;
    endsequence
    property p_alim_clip;
        s_alim_big ##1 (RD && ADDR == CAM_OFS_ALIM)
            |=> RDATA == {16'h0000, CAM_ALIM_MAX};
    endproperty
    property p_lpf_clip;
        s_lpf_big ##1 (RD && ADDR == CAM_OFS_LPF)
            |=> RDATA == {16'h0000, CAM_LPF_MAX};
    endproperty
    property p_legacy;
        LEGACY_FAULT != 3'b000 |=> COMM_FAULT;
    endproperty
    // The flag only falls through one of the two clear paths.
    property p_sticky;
        COMM_FAULT && !ERR_CLEAR && !(WR && ADDR == CAM_OFS_STAT && WDATA[0])
            |=> COMM_FAULT;
    endproperty
    property p_clear;
        COMM_FAULT && ERR_CLEAR && LEGACY_FAULT == 3'b000 && !MODEL_ACTIVE
            |=> !COMM_FAULT;
    endproperty
    property p_rd_idle;
        !RD |=> RDATA == 32'h0000_0000;
    endproperty
    property p_est_rd;
        RD && ADDR == CAM_OFS_EST |=> RDATA == {16'h0000, ESTIMATE};
    endproperty
    property p_idle_est;
        !MODEL_ACTIVE [*3] |-> ESTIMATE == 16'h0000;
    endproperty
    property p_feat_off;
        WR && ADDR == CAM_OFS_FEAT && !WDATA[CAM_FEAT_BIT]
            |-> ##[1:3] !MODEL_ACTIVE;
    endproperty
    property p_cause;
        $rose(COMM_FAULT) && $past(LEGACY_FAULT) == 3'b000
            |-> $past(MODEL_ACTIVE);
    endproperty

    a_alim_clip: assert property (p_alim_clip)
        else $error("angle limit not clipped");
    a_lpf_clip: assert property (p_lpf_clip)
        else $error("corner not clipped");
    a_legacy: assert property (p_legacy)
        else $error("older trigger did not set fault");
    a_sticky: assert property (p_sticky)
        else $error("fault dropped without clear");
    a_clear: assert property (p_clear)
        else $error("fault not cleared");
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not idle");
    a_est_rd: assert property (p_est_rd)
        else $error("estimate read mismatch");
    a_idle_est: assert property (p_idle_est)
        else $error("estimate moves while model idle");
    a_feat_off: assert property (p_feat_off)
        else $error("model runs with feature off");
    a_cause: assert property (p_cause)
        else $error("fault without cause");
endmodule

bind cam_monitor cam_monitor_chk #(.POLE_PAIRS(POLE_PAIRS)) chk_u (.CLOCK,
    .NRST, .ADDR, .WDATA, .WR, .RD, .RDATA, .LEGACY_FAULT, .ERR_CLEAR,
    .COMM_FAULT, .MODEL_ACTIVE, .ESTIMATE);
`default_nettype wire

// >>> verif/cam_drive_model.sv
// Behavioural current and velocity datapath feeding the monitor.
`timescale 1ns/100ps
`default_nettype none
module cam_drive_model
    import cam_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] gap,
    input wire logic signed [15:0] vel_set,
    input wire logic signed [15:0] uq_set,
    output logic sample,
    output logic signed [15:0] vel,
    output logic signed [15:0] iq,
    output logic signed [15:0] id,
    output logic signed [15:0] uq,
    output logic signed [15:0] ud
);
    logic [7:0] cnt;

    // Zero currents keep the voltage equation trivial; ud mirrors uq.
    assign iq = 16'sh0000;
    assign id = 16'sh0000;

    // A gap under 14 cycles would lose samples to the busy divider.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt <= 8'h00;
            sample <= 1'b0;
            vel <= 16'sh0000;
            uq <= 16'sh0000;
            ud <= 16'sh0000;
        end else begin
            cnt <= (cnt >= gap) ? 8'h00 : cnt + 8'h01;
            sample <= (cnt >= gap);
            vel <= vel_set;
            uq <= uq_set;
            ud <= uq_set;
        end
    end
endmodule
`default_nettype wire

// >>> verif/cam_monitor_test.sv
// Self-checking bench for the commutation angle monitor.
`timescale 1ns/100ps
`default_nettype none
module cam_monitor_test
    import cam_pkg::*;
;
    logic clock, nrst, wr, rd, err_clear, sample;
    logic [7:0] addr, gap;
    logic [31:0] wdata, rdata, got;
    logic signed [15:0] vel, iq, id, uq, ud, vel_set, uq_set;
    logic [2:0] legacy;
    logic comm_fault, model_active;
    logic [15:0] estimate, est_seen;
    int err_total, total_checks;
    logic [7:0] ofs [10];
    logic [31:0] rst_val [10];

    cam_drive_model drv_u (.clk(clock), .nrst(nrst), .gap(gap),
        .vel_set(vel_set), .uq_set(uq_set), .sample(sample), .vel(vel),
        .iq(iq), .id(id), .uq(uq), .ud(ud));
    cam_monitor #(.POLE_PAIRS(4)) dut_u (.CLOCK(clock), .NRST(nrst),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .SAMPLE(sample), .VEL(vel), .IQ(iq), .ID(id), .UQ(uq), .UD(ud),
        .LEGACY_FAULT(legacy), .ERR_CLEAR(err_clear),
        .COMM_FAULT(comm_fault), .MODEL_ACTIVE(model_active),
        .ESTIMATE(estimate));

    // ************************************************************
    // Clock, bus tasks and the verdict.
    // ************************************************************
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // Strobes drop on the edge itself so a next call can raise them.
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        d = rdata;
        cyc(1);
    endtask
    task automatic wr_rd(input logic [7:0] a, input logic [31:0] d,
                         input logic [31:0] e);
        wr_reg(a, d);
        rd_reg(a, got);
        chk(got, e);
    endtask
    task automatic pulse_clear();
        err_clear <= 1'b1;
        cyc(1);
        err_clear <= 1'b0;
        cyc(1);
    endtask
    task automatic conclude();
        $display("checks %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // The fault timer wait is the longest step, far below this span.
    initial begin
        repeat (100000) @(posedge clock);
        err_total++;
        conclude();
    end

    // ************************************************************
    // Test sequence.
    // ************************************************************
    initial begin
        {nrst, wr, rd, err_clear, legacy} = 7'h00;
        addr = 8'h00;
        wdata = 32'h0;
        gap = 8'h14;
        vel_set = 16'sh0000;
        uq_set = 16'sh0000;
        err_total = 0;
        total_checks = 0;
        ofs = '{CAM_OFS_FEAT, CAM_OFS_VLIM, CAM_OFS_ALIM, CAM_OFS_TOL,
            CAM_OFS_LPF, CAM_OFS_RES, CAM_OFS_IND, CAM_OFS_LSLOPE,
            CAM_OFS_STAT, 8'h30};
        rst_val = '{CAM_RST_FEAT, {16'h0, CAM_RST_VLIM}, {16'h0, CAM_RST_ALIM},
            {16'h0, CAM_RST_TOL}, {16'h0, CAM_RST_LPF}, {16'h0, CAM_RST_RES},
            {16'h0, CAM_RST_IND}, {24'h0, CAM_RST_LSLOPE}, 32'h0, 32'h0};
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        cyc(1);
        for (int i = 0; i < 10; i++) begin
            rd_reg(ofs[i], got);
            chk(got, rst_val[i]);
        end
        $display("reset values test done");
        // Each older trigger; a clear while it stands must be ignored.
        for (int i = 0; i < 3; i++) begin
            legacy <= 3'b001 << i;
            cyc(1);
            chk(comm_fault, 1'b1);
            err_clear <= 1'b1;
            cyc(1);
            err_clear <= 1'b0;
            legacy <= 3'b000;
            cyc(1);
            chk(comm_fault, 1'b1);
            if (i == 2)
                wr_reg(CAM_OFS_STAT, 32'h1);
            else
                pulse_clear();
            cyc(1);
            chk(comm_fault, 1'b0);
        end
        $display("older triggers test done");
        vel_set <= 16'sd300;
        cyc(60);
        chk(model_active, 1'b0);
        vel_set <= -16'sd400;
        cyc(60);
        chk(model_active, 1'b1);
        wr_reg(CAM_OFS_FEAT, 32'h0);
        cyc(4);
        chk(model_active, 1'b0);
        wr_reg(CAM_OFS_FEAT, CAM_RST_FEAT);
        cyc(4);
        chk(model_active, 1'b1);
        $display("model enable test done");
        wr_rd(CAM_OFS_ALIM, 32'hFFFF, {16'h0, CAM_ALIM_MAX});
        wr_rd(CAM_OFS_LPF, 32'h0, {16'h0, CAM_LPF_MIN});
        wr_rd(CAM_OFS_LPF, 32'h7D0, {16'h0, CAM_LPF_MAX});
        wr_rd(CAM_OFS_TOL, 32'h0, 32'h0);
        // Equal d and q residuals divide to a quarter of pi.
        vel_set <= 16'sd1000;
        uq_set <= 16'sd8000;
        cyc(60);
        rd_reg(CAM_OFS_RAW, got);
        chk(got, {17'h0, CAM_ANGLE_HALF_PI[15:1]});
        // Negative q voltage with no current reads as beyond ninety degrees.
        vel_set <= 16'sd1000;
        uq_set <= -16'sd8000;
        cyc(60);
        rd_reg(CAM_OFS_RAW, got);
        chk(got, {16'h0, CAM_ANGLE_PI});
        for (int n = 0; n < 60000 && comm_fault !== 1'b1; n++)
            cyc(1);
        chk(comm_fault, 1'b1);
        chk(estimate > CAM_ALIM_MAX, 1'b1);
        est_seen = estimate;
        rd_reg(CAM_OFS_EST, got);
        chk(got, {16'h0, est_seen});
        rd_reg(CAM_OFS_STAT, got);
        chk(got, 32'h7);
        pulse_clear();
        chk(comm_fault, 1'b1);
        vel_set <= 16'sh0000;
        uq_set <= 16'sh0000;
        cyc(60);
        chk(estimate, 16'h0);
        rd_reg(CAM_OFS_RAW, got);
        chk(got, 32'h0);
        pulse_clear();
        chk(comm_fault, 1'b0);
        $display("angle fault test done");
        conclude();
    end
endmodule
`default_nettype wire
